// file: hw/ubmu_pkg.sv
package ubmu_pkg;

  // ----------------------------------------------------------------
  // Cycle select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_ANY   = 2'h0;
  localparam logic [1:0] KIND_FETCH = 2'h1;
  localparam logic [1:0] KIND_DATA  = 2'h2;

  localparam logic [1:0] RW_ANY     = 2'h0;
  localparam logic [1:0] RW_READ    = 2'h1;
  localparam logic [1:0] RW_WRITE   = 2'h2;

  localparam logic [1:0] SZ_ANY     = 2'h0;
  localparam logic [1:0] SZ_BYTE    = 2'h1;
  localparam logic [1:0] SZ_WORD    = 2'h2;
  localparam logic [1:0] SZ_LONG    = 2'h3;

  // ----------------------------------------------------------------
  // Compare lane masks
  // ----------------------------------------------------------------
  localparam logic [31:0] IGN_LONG  = 32'h0000_0003;
  localparam logic [31:0] IGN_WORD  = 32'h0000_0001;
  localparam logic [31:0] IGN_BYTE  = 32'h0000_0000;
  localparam logic [31:0] LANE_LONG = 32'hFFFF_FFFF;
  localparam logic [31:0] LANE_HALF = 32'h0000_FFFF;

  localparam int unsigned CNT_W     = 16;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] amask;
    logic [7:0]  address_space_identifier;
    logic        address_space_identifier_en;
    logic        dma_sel;
    logic [1:0]  kind;
    logic [1:0]  rw;
    logic [1:0]  size;
    logic        post_exec;
  } ubmu_chan_t;

  typedef struct packed {
    ubmu_chan_t       a;
    ubmu_chan_t       b;
    logic [31:0]      data;
    logic [31:0]      dmask;
    logic             data_en;
    logic             cnt_en;
    logic [CNT_W-1:0] cnt_limit;
    logic             seq_mode;
  } ubmu_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        dma;
    logic        fetch;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] data;
    logic [7:0]  address_space_identifier;
  } ubmu_bus_t;

  typedef enum logic [4:0] {
    TK_NONE   = 5'h01,
    TK_FEXC   = 5'h02,
    TK_PRE    = 5'h04,
    TK_OPND   = 5'h08,
    TK_POST   = 5'h10
  } ubmu_take_t;

  typedef enum logic [1:0] {
    SQ_IDLE  = 2'h1,
    SQ_ARMED = 2'h2
  } ubmu_seq_t;

endpackage

// file: hw/ubmu_chan_cmp.sv
`timescale 1ns/10ps
module ubmu_chan_cmp
  import ubmu_pkg::*;
#(
  parameter bit HAS_DATA = 1'b0
) (
  input  ubmu_chan_t        cfg,
  input  wire logic [31:0]  cdata,
  input  wire logic [31:0]  cdmask,
  input  wire logic         data_en,
  input  ubmu_bus_t         bus,
  output logic              match
);

  logic [31:0] ign;
  logic [31:0] lane;
  logic        addr_ok;
  logic        kind_ok;
  logic        rw_ok;
  logic        size_ok;
  logic        address_space_identifier_ok;
  logic        data_ok;
  logic        never;

  always_comb begin
    case (bus.size)
      SZ_LONG: ign = IGN_LONG;
      SZ_WORD: ign = IGN_WORD;
      default: ign = IGN_BYTE;
    endcase
    lane    = (bus.size == SZ_LONG) ? LANE_LONG : LANE_HALF;
    addr_ok = ((bus.addr ^ cfg.addr) & ~(cfg.amask | ign)) == '0;
    kind_ok = (cfg.kind == KIND_ANY) || ((cfg.kind == KIND_FETCH) == bus.fetch);
    rw_ok   = (cfg.rw == RW_ANY) || ((cfg.rw == RW_WRITE) == bus.write);
    size_ok = (cfg.size == SZ_ANY) || (cfg.size == bus.size);
    address_space_identifier_ok = !cfg.address_space_identifier_en || (bus.address_space_identifier == cfg.address_space_identifier);
    data_ok = !HAS_DATA || !data_en || bus.fetch
              || (((bus.data ^ cdata) & ~cdmask & lane) == '0);
    // Impossible selections are refused outright
    never   = ((cfg.kind == KIND_FETCH) && (cfg.rw == RW_WRITE))
              || ((cfg.kind == KIND_FETCH) && cfg.dma_sel)
              || ((cfg.kind == KIND_FETCH) && cfg.addr[0] && !cfg.amask[0]);
    match   = bus.valid && (bus.dma == cfg.dma_sel) && addr_ok && kind_ok
              && rw_ok && size_ok && address_space_identifier_ok && data_ok && !never;
  end

endmodule

// file: hw/ubmu_exec_cnt.sv
`timescale 1ns/10ps
module ubmu_exec_cnt
  import ubmu_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         en,
  input  wire logic         hit,
  input  wire logic [W-1:0] limit,
  output logic              fire
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic [W-1:0] cnt_inc;

  always_comb begin
    cnt_inc = cnt_ff + W'(1);
    fire    = hit && (!en || (cnt_inc >= limit));
    nxt_cnt = cnt_ff;
    if (!en || fire) begin
      nxt_cnt = '0;
    end else if (hit) begin
      nxt_cnt = cnt_inc;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  a_count_fire: assert property (@(posedge clk) disable iff (!arst_n)
    (en && hit && (cnt_ff + W'(1) < limit)) |-> !fire)
    else $error("execution count fired before its limit");

endmodule

// file: hw/ubmu_top.sv
`timescale 1ns/10ps
module ubmu_top
  import ubmu_pkg::*;
(
  input  wire logic         CORE_CLK,
  input  wire logic         ARST_N,
  input  wire logic         CFG_WE,
  input  wire logic         CFG_FROM_DMA,
  input  ubmu_cfg_t         CFG_WDATA,
  input  ubmu_bus_t         BUS,
  input  wire logic         FETCH_EXC,
  input  wire logic         INSN_DONE,
  input  wire logic         OPND_EXC,
  input  wire logic         FLAG_CLR_A,
  input  wire logic         FLAG_CLR_B,
  output ubmu_cfg_t         CFG_RDATA,
  output logic              BREAK_REQ,
  output ubmu_take_t        TAKE,
  output logic              FLAG_A,
  output logic              FLAG_B
);

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  ubmu_cfg_t cfg_ff;
  ubmu_cfg_t nxt_cfg;

  always_comb begin
    nxt_cfg = cfg_ff;
    // Writer commits at its memory-access stage; DMA masters cannot reach here
    if (CFG_WE && !CFG_FROM_DMA) begin
      nxt_cfg = CFG_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Channel comparators
  // ----------------------------------------------------------------
  logic match_a;
  logic match_b;

  ubmu_chan_cmp #(
    .HAS_DATA (1'b0)
  ) u_cmp_a (
    .cfg     (cfg_ff.a),
    .cdata   (cfg_ff.data),
    .cdmask  (cfg_ff.dmask),
    .data_en (1'b0),
    .bus     (BUS),
    .match   (match_a)
  );

  ubmu_chan_cmp #(
    .HAS_DATA (1'b1)
  ) u_cmp_b (
    .cfg     (cfg_ff.b),
    .cdata   (cfg_ff.data),
    .cdmask  (cfg_ff.dmask),
    .data_en (cfg_ff.data_en),
    .bus     (BUS),
    .match   (match_b)
  );

  logic a_pre;
  logic b_pre;

  assign a_pre = (cfg_ff.a.kind == KIND_FETCH) && !cfg_ff.a.post_exec;
  assign b_pre = (cfg_ff.b.kind == KIND_FETCH) && !cfg_ff.b.post_exec;

  // ----------------------------------------------------------------
  // Sequence tracking
  // ----------------------------------------------------------------
  ubmu_seq_t seq_ff;
  ubmu_seq_t nxt_seq;
  logic      b_seq_hit;
  logic      b_hit;
  logic      fire_b;

  always_comb begin
    // B counts only if A was seen in an earlier bus cycle, or in the same cycle when A is a pre-execution fetch condition
    b_seq_hit = match_b && ((seq_ff == SQ_ARMED)
                || (match_a && a_pre));
    b_hit     = cfg_ff.seq_mode ? b_seq_hit : match_b;
    nxt_seq   = seq_ff;
    case (seq_ff)
      SQ_IDLE: begin
        if (cfg_ff.seq_mode && match_a && !b_seq_hit) begin
          nxt_seq = SQ_ARMED;
        end
      end
      SQ_ARMED: begin
        if (!cfg_ff.seq_mode || fire_b) begin
          nxt_seq = SQ_IDLE;
        end
      end
      default: nxt_seq = SQ_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      seq_ff <= SQ_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  ubmu_exec_cnt #(
    .W (CNT_W)
  ) u_cnt_b (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .en     (cfg_ff.cnt_en),
    .hit    (b_hit),
    .limit  (cfg_ff.cnt_limit),
    .fire   (fire_b)
  );

  // ----------------------------------------------------------------
  // Break qualification and exception priority
  // ----------------------------------------------------------------
  logic       qual_a;
  logic       pre_now;
  logic       post_set;
  logic       post_pend_ff;
  logic       nxt_post_pend;
  ubmu_take_t take_ff;
  ubmu_take_t nxt_take;
  logic       brk_ff;
  logic       nxt_brk;

  always_comb begin
    qual_a   = match_a && !cfg_ff.seq_mode;
    pre_now  = (qual_a && a_pre) || (fire_b && b_pre);
    post_set = (qual_a && !a_pre) || (fire_b && !b_pre);
    // Highest priority first
    if (FETCH_EXC) begin
      nxt_take = TK_FEXC;
    end else if (pre_now) begin
      nxt_take = TK_PRE;
    end else if (INSN_DONE && OPND_EXC) begin
      nxt_take = TK_OPND;
    end else if (INSN_DONE && post_pend_ff) begin
      nxt_take = TK_POST;
    end else begin
      nxt_take = TK_NONE;
    end
    nxt_brk       = (nxt_take == TK_PRE) || (nxt_take == TK_POST);
    nxt_post_pend = post_set || (post_pend_ff && !INSN_DONE);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      take_ff      <= TK_NONE;
      brk_ff       <= 1'b0;
      post_pend_ff <= 1'b0;
    end else begin
      take_ff      <= nxt_take;
      brk_ff       <= nxt_brk;
      post_pend_ff <= nxt_post_pend;
    end
  end

  // ----------------------------------------------------------------
  // Sticky match flags
  // ----------------------------------------------------------------
  logic flag_a_ff;
  logic flag_b_ff;
  logic nxt_flag_a;
  logic nxt_flag_b;

  always_comb begin
    // A set in the clearing cycle wins
    nxt_flag_a = match_a || (flag_a_ff && !FLAG_CLR_A);
    nxt_flag_b = fire_b || (flag_b_ff && !FLAG_CLR_B);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_a_ff <= 1'b0;
      flag_b_ff <= 1'b0;
    end else begin
      flag_a_ff <= nxt_flag_a;
      flag_b_ff <= nxt_flag_b;
    end
  end

  assign CFG_RDATA = cfg_ff;
  assign BREAK_REQ = brk_ff;
  assign TAKE      = take_ff;
  assign FLAG_A    = flag_a_ff;
  assign FLAG_B    = flag_b_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  a_dma_write_blocked: assert property (
    (CFG_WE && CFG_FROM_DMA) |=> (cfg_ff == $past(cfg_ff)))
    else $error("DMA write altered break settings");

  a_cfg_commit_next: assert property (
    (CFG_WE && !CFG_FROM_DMA) |=> (CFG_RDATA == $past(CFG_WDATA)))
    else $error("CPU write not visible one cycle later");

  a_chan_src_match: assert property (
    match_a |-> (BUS.dma == cfg_ff.a.dma_sel))
    else $error("channel A matched a cycle of the other master");

  a_seq_same_cycle: assert property (
    (cfg_ff.seq_mode && seq_ff == SQ_IDLE && !a_pre && match_a && match_b)
    |=> !$rose(FLAG_B))
    else $error("sequence fired on a single shared cycle");

  a_seq_no_a_seen: assert property (
    (cfg_ff.seq_mode && seq_ff == SQ_IDLE && !match_a) |-> !fire_b)
    else $error("sequence fired without channel A");

  a_seq_pre_both: assert property (
    (cfg_ff.seq_mode && !cfg_ff.cnt_en && a_pre && b_pre && match_a
     && match_b && !FETCH_EXC) |=> (FLAG_A && FLAG_B && BREAK_REQ))
    else $error("pre-execution sequence on shared cycle missed");

  a_fetch_exc_first: assert property (
    FETCH_EXC |=> (TAKE == TK_FEXC && !BREAK_REQ))
    else $error("fetch exception lost its priority");

  a_pre_over_opnd: assert property (
    (pre_now && !FETCH_EXC) |=> (TAKE == TK_PRE) ##0 BREAK_REQ)
    else $error("pre-execution break lost to operand exception");

  a_opnd_over_post: assert property (
    (INSN_DONE && OPND_EXC && post_pend_ff && !FETCH_EXC && !pre_now)
    |=> (TAKE == TK_OPND) && !BREAK_REQ)
    else $error("post-execution break beat operand exception");

  a_post_waits_done: assert property (
    (post_set && !INSN_DONE) |=> post_pend_ff && !(TAKE == TK_POST))
    else $error("post-execution break taken before completion");

  a_never_fetch_write: assert property (
    (cfg_ff.a.kind == KIND_FETCH && cfg_ff.a.rw == RW_WRITE) |-> !match_a)
    else $error("fetch-write condition matched");

  a_never_dma_fetch: assert property (
    (cfg_ff.b.kind == KIND_FETCH && cfg_ff.b.dma_sel) |-> !match_b)
    else $error("DMA fetch condition matched");

  a_flag_sticky: assert property (
    (FLAG_A && !FLAG_CLR_A) |=> FLAG_A)
    else $error("match flag dropped without clear");

  a_flag_b_sticky: assert property (
    (FLAG_B && !FLAG_CLR_B) |=> FLAG_B)
    else $error("channel B flag dropped without clear");

  a_flag_set_wins: assert property (
    (match_a && FLAG_CLR_A) |=> FLAG_A)
    else $error("clear beat a match in the same cycle");

  a_odd_fetch_never: assert property (
    (cfg_ff.b.kind == KIND_FETCH && cfg_ff.b.addr[0] && !cfg_ff.b.amask[0]) |-> !match_b)
    else $error("fetch condition on odd address matched");

  a_post_on_done: assert property (
    (INSN_DONE && post_pend_ff && !OPND_EXC && !FETCH_EXC && !pre_now) |=> (TAKE == TK_POST) && BREAK_REQ)
    else $error("pending post-execution break not taken at completion");

  a_break_has_take: assert property (
    BREAK_REQ |-> (TAKE == TK_PRE) || (TAKE == TK_POST))
    else $error("break request without a break take code");

  c_seq_break: cover property (
    cfg_ff.seq_mode && seq_ff == SQ_ARMED ##1 BREAK_REQ);
  c_count_fire: cover property (cfg_ff.cnt_en && fire_b);
  c_post_taken: cover property (TAKE == TK_POST);
  c_fetch_exc_vs_pre: cover property (FETCH_EXC && pre_now);

endmodule

// file: tb/ubmu_cpu_model.sv
`timescale 1ns/10ps
module ubmu_cpu_model
  import ubmu_pkg::*;
(
  input  wire logic clk,
  output ubmu_bus_t bus,
  output logic      fetch_exc,
  output logic      insn_done,
  output logic      opnd_exc
);
  initial begin
    bus = '0;
    {fetch_exc, insn_done, opnd_exc} = 3'h0;
  end

  // ----------------------------------------------------------------
  // Pipeline slot
  // ----------------------------------------------------------------
  // One slot per call in program order; no branch follows a trace read
  task automatic step(input ubmu_bus_t b, input logic [2:0] ev);
    @(negedge clk);
    bus = b;
    {fetch_exc, insn_done, opnd_exc} = ev;
    @(negedge clk);
    // Released bus must not keep showing the last value
    bus.valid = 1'b0;
    bus.addr = ~b.addr;
    bus.data = ~b.data;
    {fetch_exc, insn_done, opnd_exc} = 3'h0;
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench
  import ubmu_pkg::*;
();
  localparam logic [2:0] EV_NONE = 3'h0;
  localparam logic [2:0] EV_FEXC = 3'h4;
  localparam logic [2:0] EV_DONE = 3'h2;
  localparam logic [2:0] EV_OPND = 3'h3;
  localparam ubmu_bus_t  IDLE    = '0;
  logic        clk;
  logic        arst_n;
  logic        we;
  logic        from_dma;
  logic        clr_a;
  logic        clr_b;
  ubmu_cfg_t   c;
  ubmu_cfg_t   rdata;
  ubmu_bus_t   bus;
  logic        fexc;
  logic        done;
  logic        opnd;
  logic        brk;
  ubmu_take_t  take;
  logic        flag_a;
  logic        flag_b;
  logic [31:0] a;
  logic [7:0]  n;
  int          fail_count;
  int          checks_done;
  logic [31:0] da [5] = '{32'h00123454, 32'h00123456, 32'h00123456, 32'h00123457, 32'h00123454};
  logic [1:0]  ds [5] = '{SZ_LONG, SZ_WORD, SZ_BYTE, SZ_BYTE, SZ_WORD};

  ubmu_top i_ubmu_top (
    .CORE_CLK     (clk),
    .ARST_N       (arst_n),
    .CFG_WE       (we),
    .CFG_FROM_DMA (from_dma),
    .CFG_WDATA    (c),
    .BUS          (bus),
    .FETCH_EXC    (fexc),
    .INSN_DONE    (done),
    .OPND_EXC     (opnd),
    .FLAG_CLR_A   (clr_a),
    .FLAG_CLR_B   (clr_b),
    .CFG_RDATA    (rdata),
    .BREAK_REQ    (brk),
    .TAKE         (take),
    .FLAG_A       (flag_a),
    .FLAG_B       (flag_b)
  );

  ubmu_cpu_model i_ubmu_cpu_model (
    .clk       (clk),
    .bus       (bus),
    .fetch_exc (fexc),
    .insn_done (done),
    .opnd_exc  (opnd)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic ubmu_chan_t ch(logic [31:0] ad, logic [31:0] m, logic [1:0] k, logic [1:0] rw,
                                    logic [1:0] sz, logic pe);
    return '{addr:ad, amask:m, address_space_identifier:8'h00, address_space_identifier_en:1'b0, dma_sel:1'b0, kind:k, rw:rw, size:sz, post_exec:pe};
  endfunction

  function automatic ubmu_bus_t bc(logic d, logic f, logic w, logic [1:0] s, logic [31:0] ad,
                                   logic [31:0] dt, logic [7:0] id);
    return '{valid:1'b1, dma:d, fetch:f, write:w, size:s, addr:ad, data:dt, address_space_identifier:id};
  endfunction

  function automatic logic hit(logic [31:0] ad, logic [31:0] base, logic [31:0] m, logic [1:0] sz);
    logic [31:0] ign;
    ign = (sz == SZ_LONG) ? IGN_LONG : (sz == SZ_WORD) ? IGN_WORD : IGN_BYTE;
    return ((ad ^ base) & ~(m | ign)) == 32'h0;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run(input ubmu_bus_t b, input logic [2:0] ev, input ubmu_take_t tk);
    i_ubmu_cpu_model.step(b, ev);
    chk(32'(take), 32'(tk));
    chk(32'(brk), 32'(tk == TK_PRE || tk == TK_POST));
  endtask

  task automatic setc(input logic dma);
    @(negedge clk);
    we = 1'b1;
    from_dma = dma;
    @(negedge clk);
    we = 1'b0;
    from_dma = 1'b0;
  endtask

  task automatic rst();
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
  endtask

  task automatic clr();
    @(negedge clk);
    {clr_a, clr_b} = 2'h3;
    @(negedge clk);
    {clr_a, clr_b} = 2'h0;
    chk(32'({flag_a, flag_b}), 32'h0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {arst_n, we, from_dma, clr_a, clr_b} = 5'h0;
    c = '0;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(32'h1d42e9b5));
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    chk(32'(rdata === '0), 32'h1);
    chk(32'({take, flag_a, flag_b, brk}), 32'({TK_NONE, 3'h0}));
    $display("test reset done");

    c.a = ch(32'h00000404, 32'h0, KIND_FETCH, RW_READ, SZ_ANY, 1'b1);
    c.b = ch(32'h00008010, 32'h6, KIND_FETCH, RW_READ, SZ_ANY, 1'b0);
    setc(1'b1);
    chk(32'(rdata === '0), 32'h1);
    setc(1'b0);
    chk(32'(rdata === c), 32'h1);
    run(bc(0, 1, 0, SZ_WORD, 32'h404, 0, 0), EV_NONE, TK_NONE);
    run(IDLE, EV_DONE, TK_POST);
    chk(32'(flag_a), 32'h1);
    for (int i = 0; i < 7; i++) begin
      a = 32'h0000800E + 32'(2 * i);
      run(bc(0, 1, 0, SZ_WORD, a, 0, 0), EV_NONE, hit(a, 32'h8010, 32'h6, SZ_WORD) ? TK_PRE : TK_NONE);
    end
    run(bc(1, 1, 0, SZ_WORD, 32'h8010, 0, 0), EV_NONE, TK_NONE);
    c.b.addr = 32'h00009010;
    fork
      setc(1'b0);
      run(bc(0, 1, 0, SZ_WORD, 32'h9010, 0, 0), EV_NONE, TK_NONE);
    join
    run(bc(0, 1, 0, SZ_WORD, 32'h9010, 0, 0), EV_NONE, TK_PRE);
    clr();
    $display("test independent done");

    c = '0;
    c.a = ch(32'h00027128, 32'h0, KIND_FETCH, RW_WRITE, SZ_WORD, 1'b0);
    c.b = ch(32'h00031415, 32'h0, KIND_FETCH, RW_READ, SZ_ANY, 1'b0);
    setc(1'b0);
    run(bc(0, 1, 0, SZ_WORD, 32'h27128, 0, 0), EV_NONE, TK_NONE);
    run(bc(0, 1, 0, SZ_WORD, 32'h31414, 0, 0), EV_NONE, TK_NONE);
    c.a = ch(32'h00314156, 32'h0, KIND_FETCH, RW_READ, SZ_ANY, 1'b0);
    c.a.dma_sel = 1'b1;
    setc(1'b0);
    run(bc(1, 1, 0, SZ_WORD, 32'h314156, 0, 0), EV_NONE, TK_NONE);
    chk(32'({flag_a, flag_b}), 32'h0);
    $display("test never-match done");

    rst();
    c = '0;
    c.seq_mode = 1'b1;
    c.a = ch(32'h00000500, 32'h0, KIND_DATA, RW_READ, SZ_ANY, 1'b0);
    c.b = c.a;
    setc(1'b0);
    run(bc(0, 0, 0, SZ_LONG, 32'h500, 0, 0), EV_NONE, TK_NONE);
    run(IDLE, EV_DONE, TK_NONE);
    rst();
    c.a = ch(32'h00037226, 32'h0, KIND_FETCH, RW_READ, SZ_WORD, 1'b0);
    c.b = ch(32'h0003722E, 32'h0, KIND_FETCH, RW_READ, SZ_WORD, 1'b0);
    {c.a.address_space_identifier, c.a.address_space_identifier_en, c.b.address_space_identifier, c.b.address_space_identifier_en} = {8'h80, 1'b1, 8'h70, 1'b1};
    setc(1'b0);
    run(bc(0, 1, 0, SZ_WORD, 32'h3722E, 0, 8'h70), EV_NONE, TK_NONE);
    run(bc(0, 1, 0, SZ_WORD, 32'h37226, 0, 8'h70), EV_NONE, TK_NONE);
    chk(32'(flag_a), 32'h0);
    run(bc(0, 1, 0, SZ_WORD, 32'h37226, 0, 8'h80), EV_NONE, TK_NONE);
    run(bc(0, 1, 0, SZ_WORD, 32'h3722E, 0, 8'h70), EV_NONE, TK_PRE);
    chk(32'({flag_a, flag_b}), 32'h3);
    rst();
    c.b = c.a;
    setc(1'b0);
    run(bc(0, 1, 0, SZ_WORD, 32'h37226, 0, 8'h80), EV_NONE, TK_PRE);
    chk(32'({flag_a, flag_b}), 32'h3);
    $display("test sequence done");

    c = '0;
    c.a = ch(32'h00000500, 32'h0, KIND_FETCH, RW_READ, SZ_LONG, 1'b0);
    c.b = ch(32'h00001000, 32'h0, KIND_FETCH, RW_READ, SZ_LONG, 1'b0);
    {c.cnt_en, c.cnt_limit} = {1'b1, 16'h0005};
    setc(1'b0);
    for (int i = 1; i <= 5; i++) begin
      run(bc(0, 1, 0, SZ_LONG, 32'h1000, 0, 0), EV_NONE, (i == 5) ? TK_PRE : TK_NONE);
    end
    run(bc(0, 1, 0, SZ_LONG, 32'h500, 0, 0), EV_NONE, TK_PRE);
    $display("test count done");

    c = '0;
    c.a = ch(32'h00123456, 32'h0, KIND_DATA, RW_READ, SZ_ANY, 1'b0);
    setc(1'b0);
    for (int i = 0; i < 5; i++) begin
      run(bc(0, 0, 0, ds[i], da[i], 0, 0), EV_NONE, TK_NONE);
      run(IDLE, EV_DONE, hit(da[i], 32'h123456, 32'h0, ds[i]) ? TK_POST : TK_NONE);
    end
    c.b = ch(32'h000ABCDE, 32'hFF, KIND_DATA, RW_WRITE, SZ_WORD, 1'b0);
    {c.data, c.data_en} = {32'h0000A512, 1'b1};
    setc(1'b0);
    for (int i = 0; i < 2; i++) begin
      a = 32'h000ABC00 + 32'(2 * ($urandom % 128));
      run(bc(0, 0, 1, SZ_WORD, a, 32'h0000A512 + 32'(i), 0), EV_NONE, TK_NONE);
      run(IDLE, EV_DONE, (i == 0) ? TK_POST : TK_NONE);
    end
    c.b = ch(32'h00055555, 32'h0, KIND_DATA, RW_WRITE, SZ_BYTE, 1'b0);
    c.b.dma_sel = 1'b1;
    {c.data, c.dmask} = {32'h00007878, 32'h00000F0F};
    setc(1'b0);
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 8'h7F : 8'($urandom);
      run(bc(1, 0, 1, SZ_BYTE, 32'h55555, {16'h0, n, n}, 0), EV_NONE, TK_NONE);
      run(IDLE, EV_DONE, hit({24'h0, n}, 32'h78, 32'hF, SZ_BYTE) ? TK_POST : TK_NONE);
    end
    $display("test data done");

    c = '0;
    c.a = ch(32'h00002000, 32'h0, KIND_FETCH, RW_READ, SZ_ANY, 1'b0);
    c.b = ch(32'h00003000, 32'h0, KIND_DATA, RW_READ, SZ_ANY, 1'b0);
    setc(1'b0);
    run(bc(0, 1, 0, SZ_WORD, 32'h2000, 0, 0), EV_FEXC, TK_FEXC);
    run(bc(0, 1, 0, SZ_WORD, 32'h2000, 0, 0), EV_OPND, TK_PRE);
    run(bc(0, 0, 0, SZ_LONG, 32'h3000, 0, 0), EV_NONE, TK_NONE);
    run(IDLE, EV_OPND, TK_OPND);
    run(IDLE, EV_DONE, TK_NONE);
    // Clear pulse in the very cycle of a new match: the set must win
    fork
      begin
        @(negedge clk);
        {clr_a, clr_b} = 2'h3;
        @(negedge clk);
        {clr_a, clr_b} = 2'h0;
      end
      run(bc(0, 1, 0, SZ_WORD, 32'h2000, 0, 0), EV_NONE, TK_PRE);
    join
    chk(32'({flag_a, flag_b}), 32'h2);
    clr();
    $display("test priority done");
    conclude();
  end
endmodule
